/* hdl/clcd_defs.svh */
// Constants for the character display instruction unit
`ifndef CLCD_DEFS_SVH
`define CLCD_DEFS_SVH
`define CLCD_BLANK_CHAR 8'h20
`define CLCD_LINE1_LAST 7'h27
`define CLCD_LINE2_FIRST 7'h40
`define CLCD_LINE2_LAST 7'h67
`define CLCD_ONE_LINE_LAST 7'h4F
`define CLCD_SHIFT_LAST 7'h27
`define CLCD_ONE_LINE_SHIFT_LAST 7'h4F
`define CLCD_BUSY_CYCLES 16'h0020
`define CLCD_LONG_BUSY_CYCLES 16'h0080
`define CLCD_DDR_DEPTH 128
`define CLCD_CGR_DEPTH 64
`endif

/* hdl/clcd_pkg.sv */
// Types for the character display instruction unit
package clcd_pkg;
  // Host side bus sample
  typedef struct packed {
    logic register_select;
    logic read_not_write;
    logic [7:0] data;
  } clcd_bus_type;
  // Mode flags held by the decoder
  typedef struct packed {
    logic step_up;
    logic auto_shift;
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width_flag;
    logic two_lines;
    logic tall_font;
  } clcd_mode_type;
  // Sequencer states
  typedef enum logic [1:0] {
    CLCD_IDLE = 2'b00,
    CLCD_EXEC = 2'b01,
    CLCD_CLEAR = 2'b10
  } clcd_state_type;
endpackage : clcd_pkg

/* hdl/clcd_ram.sv */
// Single port RAM with registered read data
module clcd_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock
  input wire logic mclk_i,
  // Access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  // Read data
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];  // Storage, no reset to keep it a plain RAM

  // Write and registered read
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : clcd_ram

/* hdl/clcd_nibble.sv */
// Assembles host transfers into bytes in 8-bit or 4-bit mode
module clcd_nibble (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Host strobe side
  input wire logic strobe_i,
  input wire logic narrow_i,
  input wire logic [7:0] db_i,
  input wire logic rs_i,
  input wire logic rw_i,
  input wire logic resync_i,
  // Byte side
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic second_half_o
);
  logic strobe_q;  // Strobe delay for falling edge detect
  logic half;  // High when upper nibble has been taken
  logic [3:0] high_nib;  // Held upper nibble
  logic fall;

  assign fall = strobe_q & ~strobe_i;
  assign second_half_o = half;

  // Edge detector; strobe is taken as synchronous
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_i;
    end
  end

  // Nibble pairing, upper first
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half <= 1'b0;
      high_nib <= 4'h0;
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
    end else begin
      byte_valid_o <= 1'b0;
      if (resync_i || !narrow_i) begin
        half <= 1'b0;
      end
      if (fall) begin
        if (!narrow_i) begin
          // Full byte on all eight lines
          byte_valid_o <= 1'b1;
          byte_o <= db_i;
        end else if (!half) begin
          high_nib <= db_i[7:4];
          half <= 1'b1;
          // Reads present the byte at the first half
          if (rw_i) begin
            byte_valid_o <= 1'b1;
          end
        end else begin
          half <= 1'b0;
          byte_valid_o <= ~rw_i;
          byte_o <= {high_nib, db_i[7:4]};
        end
      end
    end
  end
  // Select is read live from the pins by the caller
  logic unused_rs;
  assign unused_rs = rs_i;
endmodule : clcd_nibble

/* hdl/clcd_top.sv */
// Instruction decoder and RAM sequencer of the character display unit
`include "clcd_defs.svh"
module clcd_top #(
  parameter logic [15:0] BUSY_CYCLES = `CLCD_BUSY_CYCLES,
  parameter logic [15:0] LONG_BUSY_CYCLES = `CLCD_LONG_BUSY_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Host port
  input wire logic strobe_i,
  input wire logic register_select_i,
  input wire logic read_not_write_i,
  input wire logic [3:0] bus_low_nibble_i,
  input wire logic [3:0] bus_high_nibble_i,
  output logic [3:0] bus_low_nibble_o,
  output logic [3:0] bus_high_nibble_o,
  output logic bus_low_nibble_oe_o,
  output logic bus_high_nibble_oe_o,
  // Display state
  output logic busy_indicator_o,
  output logic [6:0] address_counter_o,
  output logic [6:0] display_shift_o,
  output clcd_pkg::clcd_mode_type mode_o
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  clcd_pkg::clcd_bus_type bus;  // Sampled host bus
  clcd_pkg::clcd_state_type state;  // Sequencer state
  clcd_pkg::clcd_mode_type mode;  // Mode flags
  logic [6:0] ac;  // Address counter
  logic glyph_sel;  // Last address set chose glyph RAM
  logic [6:0] shift;  // Display shift offset
  logic [15:0] busy_cnt;  // Busy countdown
  logic byte_valid;
  logic [7:0] byte_d;
  logic second_half;
  logic [7:0] ddr_rdata;
  logic [7:0] cgr_rdata;
  logic ddr_we;
  logic cgr_we;
  logic [6:0] ddr_addr;
  logic [7:0] ram_wdata;
  logic [6:0] clr_addr;  // Sweep pointer while blanking
  logic rd_pend;  // Read data step pending
  logic strobe_q;
  logic [7:0] status;
  logic [7:0] rdata;
  logic [7:0] out_byte;
  logic wr_instr;
  logic wr_data;
  logic rd_data;

  assign bus = '{register_select: register_select_i,
                 read_not_write: read_not_write_i,
                 data: {bus_high_nibble_i, bus_low_nibble_i}};
  assign status = {state != clcd_pkg::CLCD_IDLE, ac};
  // Source of data reads follows last address set
  assign rdata = glyph_sel ? cgr_rdata : ddr_rdata;
  // Busy refuses instructions and data
  assign wr_instr = byte_valid & ~bus.register_select &
                    ~bus.read_not_write & (state == clcd_pkg::CLCD_IDLE);
  assign wr_data = byte_valid & bus.register_select &
                   ~bus.read_not_write & (state == clcd_pkg::CLCD_IDLE);
  assign rd_data = byte_valid & bus.register_select &
                   bus.read_not_write & (state == clcd_pkg::CLCD_IDLE);
  // RAM port steering
  assign ddr_we = (wr_data & ~glyph_sel) |
                  (state == clcd_pkg::CLCD_CLEAR);
  assign cgr_we = wr_data & glyph_sel;
  assign ddr_addr = (state == clcd_pkg::CLCD_CLEAR) ? clr_addr : ac;
  assign ram_wdata = (state == clcd_pkg::CLCD_CLEAR) ?
                     `CLCD_BLANK_CHAR : byte_d;

  ////////////////////////////////////////////////////////////////////////
  // Byte assembly and RAMs
  clcd_nibble u_nibble (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .strobe_i(strobe_i),
    .narrow_i(~mode.bus_width_flag),
    .db_i(bus.data),
    .rs_i(bus.register_select),
    .rw_i(bus.read_not_write),
    .resync_i(1'b0),
    .byte_valid_o(byte_valid),
    .byte_o(byte_d),
    .second_half_o(second_half)
  );

  clcd_ram #(.DEPTH(`CLCD_DDR_DEPTH), .AW(7)) u_display_ram (
    .mclk_i(mclk_i),
    .we_i(ddr_we),
    .addr_i(ddr_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ddr_rdata)
  );

  clcd_ram #(.DEPTH(`CLCD_CGR_DEPTH), .AW(6)) u_glyph_ram (
    .mclk_i(mclk_i),
    .we_i(cgr_we),
    .addr_i(ac[5:0]),
    .wdata_i(byte_d),
    .rdata_o(cgr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address step helpers

  // One step of the counter, wrapping per line mode
  function automatic logic [6:0] step_ac(input logic [6:0] a,
                                         input logic up,
                                         input logic glyph,
                                         input logic two);
    logic [6:0] r;
    r = a;
    if (glyph) begin
      r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    end else if (!two) begin
      if (up) begin
        r = (a >= `CLCD_ONE_LINE_LAST) ? 7'h00 : a + 7'h01;
      end else begin
        r = (a == 7'h00) ? `CLCD_ONE_LINE_LAST : a - 7'h01;
      end
    end else if (up) begin
      if (a == `CLCD_LINE1_LAST) begin
        r = `CLCD_LINE2_FIRST;
      end else if (a >= `CLCD_LINE2_LAST) begin
        r = 7'h00;
      end else begin
        r = a + 7'h01;
      end
    end else begin
      if (a == `CLCD_LINE2_FIRST) begin
        r = `CLCD_LINE1_LAST;
      end else if (a == 7'h00) begin
        r = `CLCD_LINE2_LAST;
      end else begin
        r = a - 7'h01;
      end
    end
    return r;
  endfunction : step_ac

  // Display offset move; left means content moves toward low columns
  function automatic logic [6:0] step_shift(input logic [6:0] s,
                                            input logic left,
                                            input logic two);
    logic [6:0] last;
    logic [6:0] r;
    last = two ? `CLCD_SHIFT_LAST : `CLCD_ONE_LINE_SHIFT_LAST;
    if (left) begin
      r = (s >= last) ? 7'h00 : s + 7'h01;
    end else begin
      r = (s == 7'h00) ? last : s - 7'h01;
    end
    return r;
  endfunction : step_shift

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and busy timer
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= clcd_pkg::CLCD_IDLE;
      busy_cnt <= 16'h0000;
      clr_addr <= 7'h00;
    end else begin
      unique case (state)
        clcd_pkg::CLCD_IDLE: begin
          if (wr_instr && byte_d == 8'h01) begin
            // Blanking sweep before the long wait
            state <= clcd_pkg::CLCD_CLEAR;
            clr_addr <= 7'h00;
            busy_cnt <= LONG_BUSY_CYCLES;
          end else if (wr_instr || wr_data || rd_data) begin
            state <= clcd_pkg::CLCD_EXEC;
            busy_cnt <= (wr_instr && byte_d[7:2] == 6'h00) ?
                        LONG_BUSY_CYCLES : BUSY_CYCLES;
          end
        end
        clcd_pkg::CLCD_CLEAR: begin
          // Walk the whole display RAM
          clr_addr <= clr_addr + 7'h01;
          if (clr_addr == 7'h7F) begin
            state <= clcd_pkg::CLCD_EXEC;
          end
        end
        clcd_pkg::CLCD_EXEC: begin
          if (busy_cnt <= 16'h0001) begin
            state <= clcd_pkg::CLCD_IDLE;
            busy_cnt <= 16'h0000;
          end else begin
            busy_cnt <= busy_cnt - 16'h0001;
          end
        end
        default: begin
          state <= clcd_pkg::CLCD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode: mode flags
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode <= '{step_up: 1'b1, bus_width_flag: 1'b1, default: 1'b0};
    end else if (wr_instr) begin
      if (byte_d[7:2] == 6'b000001) begin
        mode.step_up <= byte_d[1];
        mode.auto_shift <= byte_d[0];
      end else if (byte_d[7:3] == 5'b00001) begin
        mode.display_on <= byte_d[2];
        mode.cursor_on <= byte_d[1];
        mode.blink_on <= byte_d[0];
      end else if (byte_d[7:5] == 3'b001) begin
        mode.bus_width_flag <= byte_d[4];
        mode.two_lines <= byte_d[3];
        mode.tall_font <= byte_d[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address counter, RAM select and display shift
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ac <= 7'h00;
      glyph_sel <= 1'b0;
      shift <= 7'h00;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= rd_data;
      if (wr_instr) begin
        if (byte_d == 8'h01) begin
          ac <= 7'h00;
          glyph_sel <= 1'b0;
          shift <= 7'h00;
        end else if (byte_d[7:1] == 7'b0000001) begin
          ac <= 7'h00;
          glyph_sel <= 1'b0;
          shift <= 7'h00;
        end else if (byte_d[7:4] == 4'b0001) begin
          if (!byte_d[3]) begin
            ac <= step_ac(ac, byte_d[2], glyph_sel,
                          mode.two_lines);
          end else begin
            shift <= step_shift(shift, ~byte_d[2],
                                mode.two_lines);
          end
        end else if (byte_d[7:6] == 2'b01) begin
          ac <= {1'b0, byte_d[5:0]};
          glyph_sel <= 1'b1;
        end else if (byte_d[7]) begin
          ac <= byte_d[6:0];
          glyph_sel <= 1'b0;
        end
      end else if (wr_data || rd_pend) begin
        // Step after the access
        ac <= step_ac(ac, mode.step_up, glyph_sel, mode.two_lines);
        if (mode.auto_shift && !glyph_sel) begin
          shift <= step_shift(shift, mode.step_up,
                              mode.two_lines);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data capture and drive
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_q <= 1'b0;
      out_byte <= 8'h00;
    end else begin
      strobe_q <= strobe_i;
      if (strobe_i && !strobe_q && bus.read_not_write) begin
        out_byte <= bus.register_select ? rdata : status;
      end
    end
  end

  // Pin drivers; 4-bit mode puts the low nibble up second
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_low_nibble_o <= 4'h0;
      bus_high_nibble_o <= 4'h0;
      bus_low_nibble_oe_o <= 1'b0;
      bus_high_nibble_oe_o <= 1'b0;
    end else begin
      bus_high_nibble_oe_o <= strobe_i & bus.read_not_write;
      bus_low_nibble_oe_o <= strobe_i & bus.read_not_write &
                             mode.bus_width_flag;
      bus_low_nibble_o <= out_byte[3:0];
      if (!mode.bus_width_flag && second_half) begin
        bus_high_nibble_o <= out_byte[3:0];
      end else begin
        bus_high_nibble_o <= out_byte[7:4];
      end
    end
  end

  // Status outputs
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_indicator_o <= 1'b0;
      address_counter_o <= 7'h00;
      display_shift_o <= 7'h00;
      mode_o <= '{step_up: 1'b1, bus_width_flag: 1'b1, default: 1'b0};
    end else begin
      busy_indicator_o <= status[7];
      address_counter_o <= ac;
      display_shift_o <= shift;
      mode_o <= mode;
    end
  end
endmodule : clcd_top

/* bench/clcd_chk.sv */
// Port checker for the display instruction unit
module clcd_chk #(
  parameter logic [15:0] BUSY_CYCLES = 16'h0020,
  parameter logic [15:0] LONG_BUSY_CYCLES = 16'h0080
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Host port
  input wire logic strobe_i,
  input wire logic register_select_i,
  input wire logic read_not_write_i,
  input wire logic [3:0] bus_low_nibble_i,
  input wire logic [3:0] bus_high_nibble_i,
  input wire logic [3:0] bus_low_nibble_o,
  input wire logic [3:0] bus_high_nibble_o,
  input wire logic bus_low_nibble_oe_o,
  input wire logic bus_high_nibble_oe_o,
  // Display state
  input wire logic busy_indicator_o,
  input wire logic [6:0] address_counter_o,
  input wire logic [6:0] display_shift_o,
  input wire clcd_pkg::clcd_mode_type mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic [15:0] busy_len; // Cycles busy has stood
  ////////////////////////////////////////////////////////////////////////
  // Busy length counter, cleared while idle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_len <= 16'h0000;
    else if (busy_indicator_o) busy_len <= busy_len + 16'h0001;
    else busy_len <= 16'h0000;
  end
  // Accepted full-byte write: strobe high then low while idle
  sequence s_wr_fall;
    strobe_i ##1 (!strobe_i && !read_not_write_i && !busy_indicator_o
      && mode_o.bus_width_flag);
  endsequence
  // Byte decoded one cycle after the fall, busy pin two cycles later still
  property p_wr_busy;
    s_wr_fall |-> ##3 busy_indicator_o;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("busy missing after write");
  property p_oe_hi;
    bus_high_nibble_oe_o == ($past(strobe_i) && $past(read_not_write_i));
  endproperty
  a_oe_hi: assert property (p_oe_hi)
    else $error("upper drive enable wrong");
  property p_oe_lo;
    bus_low_nibble_oe_o == ($past(strobe_i) && $past(read_not_write_i)
      && mode_o.bus_width_flag);
  endproperty
  a_oe_lo: assert property (p_oe_lo)
    else $error("lower drive enable wrong");
  property p_status;
    $rose(strobe_i) && read_not_write_i && !register_select_i
      && mode_o.bus_width_flag |-> ##2
      {bus_high_nibble_o, bus_low_nibble_o}
      == {$past(busy_indicator_o), $past(address_counter_o)};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");
  property p_busy_min;
    $fell(busy_indicator_o) |-> busy_len >= BUSY_CYCLES - 16'h0001;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_busy_max;
    busy_indicator_o |-> busy_len < LONG_BUSY_CYCLES + 16'h00A0;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy too long");
  property p_ac_cause;
    $changed(address_counter_o) |-> busy_indicator_o
      || $past(busy_indicator_o) || $past(strobe_i, 3) || $past(strobe_i, 4);
  endproperty
  a_ac_cause: assert property (p_ac_cause)
    else $error("address moved without cause");
  property p_shift_cause;
    $changed(display_shift_o) |-> busy_indicator_o
      || $past(busy_indicator_o) || $past(strobe_i, 3) || $past(strobe_i, 4);
  endproperty
  a_shift_cause: assert property (p_shift_cause)
    else $error("shift moved without cause");
  property p_mode_cause;
    $changed(mode_o) |-> $past(strobe_i, 2) || $past(strobe_i, 3)
      || $past(strobe_i, 4);
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("mode moved without cause");
endmodule : clcd_chk

/* bench/clcd_host.sv */
// Host processor model on the parallel port
module clcd_host (
  // Clock
  input wire logic mclk_i,
  // Port toward the device
  output logic strobe_o,
  output logic register_select_o,
  output logic read_not_write_o,
  output logic [3:0] wire_high_o,
  output logic [3:0] wire_low_o,
  input wire logic [3:0] dev_high_i,
  input wire logic [3:0] dev_low_i,
  input wire logic dev_high_oe_i,
  input wire logic dev_low_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] drv_high; // Host drive, upper lines
  logic [3:0] drv_low; // Host drive, lower lines
  logic narrow; // 4-bit bus in use
  // Device wins the wire while it drives
  assign wire_high_o = dev_high_oe_i ? dev_high_i : drv_high;
  assign wire_low_o = dev_low_oe_i ? dev_low_i : drv_low;
  initial begin
    strobe_o = 1'b0;
    register_select_o = 1'b0;
    read_not_write_o = 1'b0;
    {drv_high, drv_low} = 8'h00;
    narrow = 1'b0;
  end
  // One strobe: selects first, data held past the falling edge
  task automatic strobe_one(input logic rs, input logic rw,
      input logic [7:0] d, output logic [7:0] r);
    @(posedge mclk_i) #1;
    register_select_o = rs;
    read_not_write_o = rw;
    {drv_high, drv_low} = d;
    @(posedge mclk_i) #1;
    strobe_o = 1'b1;
    repeat (3) @(posedge mclk_i);
    // Sample off the edge, once the pins have settled
    #1 r = {wire_high_o, wire_low_o};
    strobe_o = 1'b0;
    @(posedge mclk_i) #1;
    {drv_high, drv_low} = ~d; // Released lines do not keep the value
  endtask : strobe_one
  // Byte transfer, split in halves on the upper lines when narrow
  task automatic xfer(input logic rs, input logic rw,
      input logic [7:0] d, output logic [7:0] r);
    logic [7:0] a;
    logic [7:0] b;
    if (!narrow) strobe_one(rs, rw, d, r);
    else begin
      strobe_one(rs, rw, {d[7:4], 4'h0}, a);
      strobe_one(rs, rw, {d[3:0], 4'h0}, b);
      r = {a[7:4], b[7:4]};
    end
  endtask : xfer
  // Poll status until busy clears; the watchdog cuts a hang
  task automatic wait_idle();
    logic [7:0] s;
    do xfer(1'b0, 1'b1, 8'h00, s);
    while (s[7] !== 1'b0);
  endtask : wait_idle
endmodule : clcd_host

/* bench/tb.sv */
// Self-checking testbench of the display instruction unit
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BUSY_CYCLES = 16'h0010;
  localparam logic [15:0] LONG_BUSY_CYCLES = 16'h0018;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic strobe, rs, rw, oe_h, oe_l, busy;
  logic [3:0] w_h, w_l, d_h, d_l;
  logic [6:0] ac, shift;
  clcd_pkg::clcd_mode_type mode;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rd;
  always #25 mclk_i = ~mclk_i;
  clcd_top #(.BUSY_CYCLES(BUSY_CYCLES),
    .LONG_BUSY_CYCLES(LONG_BUSY_CYCLES)) i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .strobe_i(strobe),
    .register_select_i(rs), .read_not_write_i(rw),
    .bus_low_nibble_i(w_l), .bus_high_nibble_i(w_h),
    .bus_low_nibble_o(d_l), .bus_high_nibble_o(d_h),
    .bus_low_nibble_oe_o(oe_l), .bus_high_nibble_oe_o(oe_h),
    .busy_indicator_o(busy), .address_counter_o(ac),
    .display_shift_o(shift), .mode_o(mode));
  clcd_host i_host (.mclk_i(mclk_i), .strobe_o(strobe),
    .register_select_o(rs), .read_not_write_o(rw),
    .wire_high_o(w_h), .wire_low_o(w_l), .dev_high_i(d_h),
    .dev_low_i(d_l), .dev_high_oe_i(oe_h), .dev_low_oe_i(oe_l));
  ////////////////////////////////////////////////////////////////////////
  // Instruction or data write, settled on both sides
  task automatic wr(input logic sel, input logic [7:0] d);
    i_host.wait_idle();
    i_host.xfer(sel, 1'b0, d, rd);
    i_host.wait_idle();
  endtask : wr
  // Status read with busy clear
  task automatic ac_is(input logic [6:0] e);
    i_host.wait_idle();
    i_host.xfer(1'b0, 1'b1, 8'h00, rd);
    `CHK(rd, {1'b0, e})
  endtask : ac_is
  // Data read
  task automatic rd_is(input logic [7:0] e);
    i_host.wait_idle();
    i_host.xfer(1'b1, 1'b1, 8'h00, rd);
    `CHK(rd, e)
  endtask : rd_is
  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #3000000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 arst_n_i = 1'b1;
    `CHK(mode, 8'h84)
    wr(1'b0, 8'h3C);
    `CHK(mode[1:0], 2'b11)
    for (int i = 8; i < 16; i++) begin
      wr(1'b0, 8'(i));
      `CHK(mode[5:3], 3'(i))
    end
    wr(1'b0, 8'h06);
    wr(1'b0, 8'h90);
    ac_is(7'h10);
    wr(1'b1, 8'h41);
    wr(1'b1, 8'h42);
    ac_is(7'h12);
    wr(1'b0, 8'h90);
    rd_is(8'h41);
    ac_is(7'h11);
    wr(1'b0, 8'h04);
    wr(1'b1, 8'h43);
    ac_is(7'h10);
    wr(1'b0, 8'h07);
    wr(1'b1, 8'h44);
    `CHK(shift, 7'h01)
    wr(1'b0, 8'h05);
    wr(1'b1, 8'h45);
    `CHK(shift, 7'h00)
    wr(1'b0, 8'h14);
    ac_is(7'h11);
    wr(1'b0, 8'h13);
    ac_is(7'h10);
    wr(1'b0, 8'h1B);
    ac_is(7'h10);
    `CHK(shift, 7'h01)
    wr(1'b0, 8'h1C);
    `CHK(shift, 7'h00)
    wr(1'b0, 8'h18);
    wr(1'b0, 8'h03);
    ac_is(7'h00);
    `CHK(shift, 7'h00)
    wr(1'b0, 8'h90);
    rd_is(8'h44);
    wr(1'b0, 8'h45);
    wr(1'b1, 8'h1F);
    wr(1'b0, 8'h45);
    rd_is(8'h1F);
    wr(1'b0, 8'h4A);
    ac_is(7'h0A);
    wr(1'b0, 8'hE7);
    ac_is(7'h67);
    wr(1'b0, 8'h01);
    ac_is(7'h00);
    wr(1'b0, 8'h90);
    rd_is(8'h20);
    i_host.wait_idle(); // The read leaves the unit busy
    i_host.xfer(1'b0, 1'b0, 8'hA2, rd);
    i_host.xfer(1'b0, 1'b0, 8'hB3, rd);
    ac_is(7'h22);
    wr(1'b0, 8'h30);
    `CHK(mode[1:0], 2'b00)
    wr(1'b0, 8'h80);
    wr(1'b1, 8'h4E);
    ac_is(7'h4F);
    i_host.wait_idle();
    i_host.xfer(1'b0, 1'b0, 8'h28, rd);
    i_host.narrow = 1'b1; // Pair nibbles from the very next strobe
    i_host.wait_idle();
    `CHK(mode.bus_width_flag, 1'b0)
    wr(1'b0, 8'h85);
    ac_is(7'h05);
    wr(1'b1, 8'h5A);
    wr(1'b0, 8'h85);
    rd_is(8'h5A);
    test_done();
  end
endmodule : tb
bind clcd_top clcd_chk #(.BUSY_CYCLES(BUSY_CYCLES),
  .LONG_BUSY_CYCLES(LONG_BUSY_CYCLES)) i_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .strobe_i(strobe_i),
  .register_select_i(register_select_i),
  .read_not_write_i(read_not_write_i),
  .bus_low_nibble_i(bus_low_nibble_i),
  .bus_high_nibble_i(bus_high_nibble_i),
  .bus_low_nibble_o(bus_low_nibble_o),
  .bus_high_nibble_o(bus_high_nibble_o),
  .bus_low_nibble_oe_o(bus_low_nibble_oe_o),
  .bus_high_nibble_oe_o(bus_high_nibble_oe_o),
  .busy_indicator_o(busy_indicator_o),
  .address_counter_o(address_counter_o),
  .display_shift_o(display_shift_o), .mode_o(mode_o));
